// *** pkg/sfbp_pkg.sv ***
// shared constants and types for the serial flash buffer program block
package sfbp_pkg;
  localparam logic [7:0] OP_BUF1_LOAD = 8'h84;
  localparam logic [7:0] OP_BUF2_LOAD = 8'h87;
  localparam logic [7:0] OP_BUF1_PROG_ERASE = 8'h83;
  localparam logic [7:0] OP_BUF2_PROG_ERASE = 8'h86;
  localparam logic [7:0] OP_BUF1_PROG_KEEP = 8'h88;
  localparam logic [7:0] OP_BUF2_PROG_KEEP = 8'h89;
  localparam logic [7:0] OP_BUF1_LOAD_ERASE = 8'h82;
  localparam logic [7:0] OP_BUF2_LOAD_ERASE = 8'h85;
  localparam logic [7:0] OP_BYTE_PROG = 8'h02;
  localparam int PAGE_STD = 264;
  localparam int PAGE_BIN = 256;
  localparam logic [8:0] LAST_IDX_STD = 9'h107;
  localparam logic [8:0] LAST_IDX_BIN = 9'h0ff;
  localparam int PAGE_W = 11;
  localparam int IDX_W = 9;
  localparam logic [1:0] ADDR_BYTES = 2'h3;
  localparam int ITEM_W = 1 + PAGE_W + IDX_W + 8;
  localparam int FIFO_DEPTH = 16;
  localparam int CLK_MHZ = 25;
  localparam int T_EP_US = 35000;
  localparam int T_P_US = 4000;
  localparam int T_BP_US = 8;
  localparam logic [2:0] SYNC_RESET = 3'h7;
  typedef enum logic [2:0] {
    ST_IDLE, ST_OPCODE, ST_ADDR, ST_DATA, ST_SKIP, ST_ERASE, ST_WALK, ST_DRAIN
  } sfbp_state_e;
  function automatic logic is_load(input logic [7:0] op);
    return op == OP_BUF1_LOAD || op == OP_BUF2_LOAD ||
           op == OP_BUF1_LOAD_ERASE || op == OP_BUF2_LOAD_ERASE ||
           op == OP_BYTE_PROG;
  endfunction
  function automatic logic is_prog(input logic [7:0] op);
    return op != OP_BUF1_LOAD && op != OP_BUF2_LOAD;
  endfunction
  function automatic logic sel_buf2(input logic [7:0] op);
    return op == OP_BUF2_LOAD || op == OP_BUF2_PROG_ERASE ||
           op == OP_BUF2_PROG_KEEP || op == OP_BUF2_LOAD_ERASE;
  endfunction
  function automatic logic with_erase(input logic [7:0] op);
    return op == OP_BUF1_PROG_ERASE || op == OP_BUF2_PROG_ERASE ||
           op == OP_BUF1_LOAD_ERASE || op == OP_BUF2_LOAD_ERASE;
  endfunction
  function automatic logic [PAGE_W-1:0] page_of(input logic [23:0] a,
                                                input logic bin);
    return bin ? a[18:8] : a[19:9];
  endfunction
  function automatic logic [IDX_W-1:0] idx_of(input logic [23:0] a,
                                              input logic bin);
    return bin ? {1'b0, a[7:0]} : a[8:0];
  endfunction
  function automatic logic [IDX_W-1:0] last_of(input logic bin);
    return bin ? LAST_IDX_BIN : LAST_IDX_STD;
  endfunction
  function automatic logic is_busy(input sfbp_state_e s);
    return s == ST_ERASE || s == ST_WALK || s == ST_DRAIN;
  endfunction
endpackage

// *** core/sfbp_fifo.sv ***
// first-in first-out buffer between the page walker and the array port
`timescale 1ns/1ps
`default_nettype none
module sfbp_fifo #(
  parameter int WIDTH = 29,
  parameter int DEPTH = 16
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q, wr_d, rd_q, rd_d;
  logic push, pop, full, empty;

  always_comb begin
    empty = (wr_q == rd_q);
    full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    in_ready = !full;
    out_valid = !empty;
    push = in_valid && !full;
    pop = out_ready && !empty;
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    out_data = mem_q[rd_q[AW-1:0]];
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // storage carries no reset; only words behind the pointers are read
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
endmodule
`default_nettype wire

// *** core/sfbp_core.sv ***
// serial command decoder, page buffers and self-timed page program sequencer
`timescale 1ns/1ps
`default_nettype none
//Contract
// - 84h/87h load buffer, 9-bit start index
// - binary mode: 16 dummy bits, 8-bit index
// - data bytes fill buffer, wrap, end at deselect
// - 83h/86h erase then program, page address
// - binary mode page from linear bits 18..8
// - deselect starts erase plus program, busy shown
// - failed location sets the error flag
// - 88h/89h program without erase, page address
// - binary mode 88h/89h page from bits 18..8
// - no erase program, busy up to program time
// - 82h/85h load then erase and program
// - binary mode 82h/85h page and 8-bit index
// - 82h/85h load wraps, then erase and program
// - 02h loads buffer one, no erase
// - binary 02h forms 19-bit linear location
// - 02h programs only bytes actually received
// - deselect mid-byte aborts 02h, nothing programmed
// - 02h time scales per byte, capped
module sfbp_core
  import sfbp_pkg::*;
#(
  parameter int unsigned T_EP_CYC = T_EP_US * CLK_MHZ,
  parameter int unsigned T_P_CYC = T_P_US * CLK_MHZ,
  parameter int unsigned T_BP_CYC = T_BP_US * CLK_MHZ
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic sck,
  input wire logic si,
  input wire logic binary_page_mode,
  output logic device_idle_flag,
  output logic program_erase_error_flag,
  output logic arr_valid,
  input wire logic arr_ready,
  output logic arr_erase,
  output logic [PAGE_W-1:0] arr_page,
  output logic [IDX_W-1:0] arr_index,
  output logic [7:0] arr_data,
  input wire logic arr_fail
);

  // pin synchronisers: a clock or select level counts once stages two and three agree; data takes stage three
  logic [2:0] sck_s_q, cs_s_q, si_s_q;
  logic sck_f_q, sck_f_d, cs_f_q, cs_f_d, si_f_d, sck_rise, cs_fall, cs_rise;

  always_comb begin
    sck_f_d = (sck_s_q[1] == sck_s_q[2]) ? sck_s_q[2] : sck_f_q;
    cs_f_d = (cs_s_q[1] == cs_s_q[2]) ? cs_s_q[2] : cs_f_q;
    si_f_d = si_s_q[2];
    sck_rise = sck_f_d && !sck_f_q;
    cs_fall = !cs_f_d && cs_f_q;
    cs_rise = cs_f_d && !cs_f_q;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sck_s_q <= '0;
      cs_s_q <= SYNC_RESET;
      si_s_q <= '0;
      sck_f_q <= 1'b0;
      cs_f_q <= 1'b1;
    end else begin
      sck_s_q <= {sck_s_q[1:0], sck};
      cs_s_q <= {cs_s_q[1:0], cs_b};
      si_s_q <= {si_s_q[1:0], si};
      sck_f_q <= sck_f_d;
      cs_f_q <= cs_f_d;
    end
  end

  sfbp_state_e state_q, state_d;
  logic [7:0] op_q, op_d, sh_q, sh_d, byte_in, rd_byte;
  logic [2:0] bit_q, bit_d;
  logic [1:0] abyte_q, abyte_d;
  logic [23:0] addr_q, addr_d;
  logic bin_q, bin_d, pbuf_q, pbuf_d, only_q, only_d, err_q, err_d, idle_q;
  logic [IDX_W-1:0] idx_q, idx_d, widx_q, widx_d, nbytes_q, nbytes_d;
  logic [PAGE_W-1:0] page_q, page_d;
  logic [PAGE_STD-1:0] mask_q, mask_d;
  logic [31:0] tmr_q, tmr_d, t02;
  logic wr_en, start, push, fifo_ready, fifo_valid, done_byte;
  logic [ITEM_W-1:0] push_item, pop_item;
  logic [7:0] buf1_q [PAGE_STD];
  logic [7:0] buf2_q [PAGE_STD];

  always_comb begin
    byte_in = {sh_q[6:0], si_f_d};
    done_byte = sck_rise && bit_q == 3'h7;
    rd_byte = pbuf_q ? buf2_q[widx_q] : buf1_q[widx_q];
    t02 = 32'(nbytes_q) * T_BP_CYC;
    state_d = state_q;
    op_d = op_q;
    sh_d = sh_q;
    bit_d = bit_q;
    abyte_d = abyte_q;
    addr_d = addr_q;
    bin_d = bin_q;
    pbuf_d = pbuf_q;
    only_d = only_q;
    idx_d = idx_q;
    widx_d = widx_q;
    nbytes_d = nbytes_q;
    page_d = page_q;
    mask_d = mask_q;
    tmr_d = (is_busy(state_q) && tmr_q != 32'h0) ? tmr_q - 32'h1 : tmr_q;
    wr_en = 1'b0;
    start = 1'b0;
    push = 1'b0;
    push_item = {1'b0, page_q, widx_q, rd_byte};
    if (sck_rise && (state_q == ST_OPCODE || state_q == ST_ADDR ||
                     state_q == ST_DATA)) begin
      sh_d = byte_in;
      bit_d = bit_q + 3'h1;
    end
    case (state_q)
      ST_IDLE: begin
        if (cs_fall) begin
          state_d = ST_OPCODE;
          bit_d = 3'h0;
          abyte_d = 2'h0;
        end
      end
      ST_OPCODE: begin
        if (cs_rise) begin
          state_d = ST_IDLE;
        end else if (done_byte) begin
          op_d = byte_in;
          bin_d = binary_page_mode;
          case (byte_in)
            OP_BUF1_LOAD, OP_BUF2_LOAD, OP_BUF1_PROG_ERASE,
            OP_BUF2_PROG_ERASE, OP_BUF1_PROG_KEEP, OP_BUF2_PROG_KEEP,
            OP_BUF1_LOAD_ERASE, OP_BUF2_LOAD_ERASE, OP_BYTE_PROG: begin
              state_d = ST_ADDR;
            end
            default: begin
              state_d = ST_SKIP;
            end
          endcase
          if (is_load(byte_in)) begin
            mask_d = '0;
            nbytes_d = '0;
          end
        end
      end
      ST_ADDR, ST_DATA: begin
        if (cs_rise) begin
          state_d = ST_IDLE;
          // missing address aborts; for 02h a partial byte or no bytes also aborts
          if (state_q == ST_DATA && is_prog(op_q) && (bit_q == 3'h0 ||
              op_q != OP_BYTE_PROG) && !(op_q == OP_BYTE_PROG &&
              nbytes_q == '0)) begin
            start = 1'b1;
          end
        end else if (done_byte && state_q == ST_ADDR) begin
          addr_d = {addr_q[15:0], byte_in};
          abyte_d = abyte_q + 2'h1;
          if (abyte_q == ADDR_BYTES - 2'h1) begin
            state_d = ST_DATA;
            page_d = page_of({addr_q[15:0], byte_in}, bin_q);
            idx_d = idx_of({addr_q[15:0], byte_in}, bin_q);
          end
        end else if (done_byte && is_load(op_q)) begin
          // store byte and wrap at buffer end
          wr_en = 1'b1;
          idx_d = (idx_q == last_of(bin_q)) ? '0 : idx_q + 9'h1;
          mask_d[idx_q] = 1'b1;
          if (nbytes_q != last_of(bin_q) + 9'h1) begin
            nbytes_d = nbytes_q + 9'h1;
          end
        end
      end
      ST_SKIP: begin
        if (cs_f_q) begin
          state_d = ST_IDLE;
        end
      end
      ST_ERASE: begin
        push = 1'b1;
        push_item = {1'b1, page_q, 9'h0, 8'hff};
        if (fifo_ready) begin
          state_d = ST_WALK;
        end
      end
      ST_WALK: begin
        // for 02h only bytes received are sent to the array
        push = !only_q || mask_q[widx_q];
        if (fifo_ready || !push) begin
          widx_d = widx_q + 9'h1;
          if (widx_q == last_of(bin_q)) begin
            state_d = ST_DRAIN;
          end
        end
      end
      ST_DRAIN: begin
        if (!fifo_valid && tmr_q == 32'h0) begin
          state_d = cs_f_q ? ST_IDLE : ST_SKIP;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    if (start) begin
      pbuf_d = sel_buf2(op_q);
      only_d = (op_q == OP_BYTE_PROG);
      widx_d = '0;
      // plain program skips the erase step
      state_d = with_erase(op_q) ? ST_ERASE : ST_WALK;
      if (with_erase(op_q)) begin
        tmr_d = T_EP_CYC;
      end else if (op_q == OP_BYTE_PROG) begin
        // per-byte time, never above the program limit
        tmr_d = (t02 > T_P_CYC) ? T_P_CYC : t02;
      end else begin
        tmr_d = T_P_CYC;
      end
    end
    // failure report sets the flag; it wins over the clear
    err_d = (err_q && !start) || (arr_valid && arr_ready && arr_fail);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      op_q <= '0;
      sh_q <= '0;
      bit_q <= '0;
      abyte_q <= '0;
      addr_q <= '0;
      bin_q <= 1'b0;
      pbuf_q <= 1'b0;
      only_q <= 1'b0;
      idx_q <= '0;
      widx_q <= '0;
      nbytes_q <= '0;
      page_q <= '0;
      mask_q <= '0;
      tmr_q <= '0;
      err_q <= 1'b0;
      idle_q <= 1'b1;
    end else begin
      state_q <= state_d;
      op_q <= op_d;
      sh_q <= sh_d;
      bit_q <= bit_d;
      abyte_q <= abyte_d;
      addr_q <= addr_d;
      bin_q <= bin_d;
      pbuf_q <= pbuf_d;
      only_q <= only_d;
      idx_q <= idx_d;
      widx_q <= widx_d;
      nbytes_q <= nbytes_d;
      page_q <= page_d;
      mask_q <= mask_d;
      tmr_q <= tmr_d;
      err_q <= err_d;
      idle_q <= !is_busy(state_d);
    end
  end

  // buffers are plain storage; contents after power-up are undefined
  always_ff @(posedge ref_clk) begin
    if (wr_en && sel_buf2(op_q)) begin
      buf2_q[idx_q] <= byte_in;
    end else if (wr_en) begin
      buf1_q[idx_q] <= byte_in;
    end
  end

  sfbp_fifo #(.WIDTH(ITEM_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .in_valid(push),
    .in_ready(fifo_ready),
    .in_data(push_item),
    .out_valid(fifo_valid),
    .out_ready(arr_ready),
    .out_data(pop_item)
  );

  always_comb begin
    arr_valid = fifo_valid;
    {arr_erase, arr_page, arr_index, arr_data} = pop_item;
    device_idle_flag = idle_q;
    program_erase_error_flag = err_q;
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  a_busy_on_start: assert property (start |=> !device_idle_flag)
    else $error("busy not shown after program start");
  a_erase_first: assert property (start && with_erase(op_q)
    |=> state_q == ST_ERASE ##1 !device_idle_flag)
    else $error("erase step not entered");
  a_no_erase_step: assert property (start && !with_erase(op_q)
    |=> state_q == ST_WALK)
    else $error("program without erase entered erase");
  a_midbyte_abort: assert property (cs_rise && state_q == ST_DATA &&
    op_q == OP_BYTE_PROG && bit_q != 3'h0 |-> !start)
    else $error("partial byte did not abort");
  a_index_wraps: assert property (wr_en && idx_q == last_of(bin_q)
    |=> idx_q == '0)
    else $error("buffer index did not wrap");
  a_masked_skip: assert property (state_q == ST_WALK && only_q &&
    !mask_q[widx_q] |-> !push)
    else $error("unreceived byte sent to array");
  a_error_sets: assert property (arr_valid && arr_ready && arr_fail
    |=> program_erase_error_flag)
    else $error("failure not flagged");
  a_byte_timer: assert property (start && op_q == OP_BYTE_PROG
    |=> tmr_q <= T_P_CYC && tmr_q >= T_BP_CYC)
    else $error("byte program time out of range");
  a_page_binary: assert property (state_q == ST_ADDR && bin_q &&
    state_d == ST_DATA |=> page_q == addr_q[18:8])
    else $error("binary page select wrong");

  c_load_only: cover property (cs_rise && state_q == ST_DATA &&
    !is_prog(op_q));
  c_erase_prog: cover property (start && with_erase(op_q));
  c_byte_prog: cover property (start && op_q == OP_BYTE_PROG);
  c_fifo_full: cover property (push && !fifo_ready);
endmodule
`default_nettype wire

// *** verification/sfbp_host_model.sv ***
// behavioural serial host driving chip select, serial clock and data
`timescale 1ns/1ps
`default_nettype none
module sfbp_host_model (
  input wire logic ref_clk,
  output logic cs_b,
  output logic sck,
  output logic si
);
  initial begin
    cs_b = 1'b1;
    sck = 1'b0;
    si = 1'b0;
  end

  // half link period is four system cycles
  task automatic hold4();
    repeat (4) @(posedge ref_clk);
  endtask

  // mode 0: data set while clock low, msb first
  task automatic bit_out(input logic v);
    si <= v;
    hold4();
    sck <= 1'b1;
    hold4();
    sck <= 1'b0;
  endtask

  task automatic send(input logic [7:0] q[$], input int extra);
    cs_b <= 1'b0;
    hold4();
    foreach (q[i]) for (int b = 7; b >= 0; b--) bit_out(q[i][b]);
    // whole bytes only, unless a stray tail is asked for
    for (int b = 0; b < extra; b++) bit_out(1'b1);
    hold4();
    cs_b <= 1'b1;
    // released line must not keep showing the last bit
    si <= ~si;
  endtask
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// self-checking bench for the serial flash buffer program block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sfbp_pkg::*;
  localparam int ERASE_PROGRAM_TIME_MAX = 400;
  localparam int TP = 300;
  localparam int BYTE_PROGRAM_TIME = 140;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic binary_page_mode = 1'b0;
  logic arr_ready = 1'b0;
  logic arr_fail = 1'b0;
  logic cs_b, sck, si, idle, err, arr_valid, arr_erase;
  logic [PAGE_W-1:0] arr_page;
  logic [IDX_W-1:0] arr_index;
  logic [7:0] arr_data;
  int n_fail = 0;
  int seed = 30931;
  int n_mismatch = 0;
  int samples_checked = 0;
  int fail_en = 0;
  int e;
  int bm[int];
  int exq[$];

  always #20 ref_clk = ~ref_clk;

  sfbp_host_model u_host (.ref_clk(ref_clk), .cs_b(cs_b), .sck(sck),
    .si(si));
  sfbp_core #(.T_EP_CYC(ERASE_PROGRAM_TIME_MAX), .T_P_CYC(TP), .T_BP_CYC(BYTE_PROGRAM_TIME)) u_dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .cs_b(cs_b), .sck(sck), .si(si),
    .binary_page_mode(binary_page_mode), .device_idle_flag(idle),
    .program_erase_error_flag(err), .arr_valid(arr_valid),
    .arr_ready(arr_ready), .arr_erase(arr_erase), .arr_page(arr_page),
    .arr_index(arr_index), .arr_data(arr_data), .arr_fail(arr_fail));

  task automatic check(input logic ok, input string msg);
    samples_checked++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // array side stalls at random so the fifo backs up
  always @(posedge ref_clk) begin
    arr_ready <= $random(seed) % 4 != 0;
    arr_fail <= fail_en != 0 && $random(seed) % 8 == 0;
    if (arr_valid === 1'b1 && arr_ready === 1'b1) begin
      if (arr_fail === 1'b1) n_fail++;
      if (exq.size() == 0) begin
        check(1'b0, "unexpected array item");
      end else begin
        e = exq.pop_front();
        check(arr_erase === e[28] && arr_page === e[27:17], "kind or page");
        if (!e[28]) check(arr_index === e[16:8], "item index");
        if (e[29]) check(arr_data === e[7:0], "item data");
      end
    end
  end

  task automatic run(input logic [7:0] op, input logic bin, input int page,
    input int idx, input int n, input int extra);
    logic [7:0] q[$];
    logic [23:0] a;
    int sz, b, t, busy, nf0;
    int got[int];
    logic prog, ers, ld;
    sz = bin ? PAGE_BIN : PAGE_STD;
    b = op inside {8'h87, 8'h86, 8'h89, 8'h85} ? 1024 : 0;
    ld = op inside {8'h84, 8'h87, 8'h82, 8'h85, 8'h02};
    ers = op inside {8'h83, 8'h86, 8'h82, 8'h85};
    prog = op inside {8'h83, 8'h86, 8'h88, 8'h89, 8'h82, 8'h85, 8'h02};
    prog = prog && extra == 0;
    // leading bits are dummies and sent as ones on purpose
    a = bin ? {5'h1f, page[10:0], idx[7:0]} : {4'hf, page[10:0], idx[8:0]};
    q = {op, a[23:16], a[15:8], a[7:0]};
    for (int i = 0; i < n; i++) begin
      q.push_back(8'($random(seed)));
      if (ld) bm[b + (idx + i) % sz] = q[4 + i];
      if (op == 8'h02 && extra == 0) got[(idx + i) % sz] = q[4 + i];
    end
    // the array walk runs upwards, so a wrapped load arrives low index first
    foreach (got[k]) exq.push_back(1<<29 | page<<17 | k<<8 | got[k]);
    if (extra != 0) bm.delete();
    if (ers) exq.push_back(1<<28 | page<<17);
    if (prog && op != 8'h02)
      for (int i = 0; i < sz; i++)
        exq.push_back((bm.exists(b + i) ? 1<<29 | bm[b + i] : 0) | page<<17 | i<<8);
    nf0 = n_fail;
    @(posedge ref_clk);
    binary_page_mode <= bin;
    u_host.send(q, extra);
    t = 0;
    while (idle === 1'b1 && t < 20) begin
      @(negedge ref_clk);
      t++;
    end
    check((idle === 1'b0) == prog, "busy flag after deselect");
    busy = 0;
    while (idle !== 1'b1 && busy < 5000) begin
      @(negedge ref_clk);
      busy++;
    end
    t = ers ? ERASE_PROGRAM_TIME_MAX : TP;
    if (op == 8'h02 && n * BYTE_PROGRAM_TIME < TP) t = n * BYTE_PROGRAM_TIME;
    check(idle === 1'b1, "device stays busy");
    if (prog) check(busy + 2 >= t, "busy too short");
    check(exq.size() == 0, "array items missing");
    if (prog) check(err === (n_fail != nf0), "error flag");
  endtask

  initial begin
    #(60000 * 40);
    n_mismatch++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    conclude();
  end

  // each run polls idle before the next frame
  initial begin
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    check(idle === 1'b1 && err === 1'b0, "reset flags");
    run(8'h84, 0, 0, 262, 4, 0);
    run(8'h83, 0, 5, 0, 0, 0);
    run(8'h87, 1, 0, 254, 3, 0);
    run(8'h89, 1, 2047, 0, 0, 0);
    run(8'h88, 0, 1, 0, 0, 0);
    run(8'h81, 0, 9, 0, 1, 0);
    run(8'h86, 1, 2, 0, 0, 0);
    fail_en = 1;
    run(8'h82, 0, 3, 263, 2, 0);
    fail_en = 0;
    run(8'h85, 1, 4, 0, 2, 0);
    run(8'h02, 1, 6, 255, 2, 0);
    run(8'h02, 0, 7, 0, 3, 0);
    run(8'h02, 0, 8, 0, 1, 3);
    conclude();
  end
endmodule
`default_nettype wire
